// ---- hdl/sac_pkg.sv ----
// constants, field layout and helpers of the converter control block
// assumes one 25 MHz system clock and an AXI4-Lite register bus
package sac_pkg;
    // register byte addresses
    localparam logic [7:0] ADDR_CTRL0 = 8'h00;
    localparam logic [7:0] ADDR_CTRL1 = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_RESULT0 = 8'h10;
    localparam int NUM_SOURCES = 10;
    // converter_control_0 fields
    localparam int CH_LSB = 0;
    localparam int MODE_LSB = 3;
    localparam int TRG_BIT = 5;
    localparam int START_BIT = 6;
    localparam int FSEL0_BIT = 7;
    // converter_control_1 fields
    localparam int EXT_BIT = 0;
    localparam int SH_BIT = 2;
    localparam int RES_BIT = 3;
    localparam int FSEL1_BIT = 4;
    localparam int VREF_BIT = 5;
    // reset values
    localparam logic [7:0] CTRL0_RESET = 8'h00;
    localparam logic [7:0] CTRL1_RESET = 8'h00;
    localparam logic [9:0] RESULT_RESET = 10'h000;
    // conversion length in conversion-clock cycles
    localparam logic [6:0] CYC_8_PLAIN = 7'd49;
    localparam logic [6:0] CYC_10_PLAIN = 7'd59;
    localparam logic [6:0] CYC_8_SH = 7'd28;
    localparam logic [6:0] CYC_10_SH = 7'd33;
    localparam logic [3:0] BITS_8 = 4'h8;
    localparam logic [3:0] BITS_10 = 4'hA;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [0:0] {
        SEQ_IDLE = 1'b0,
        SEQ_CONV = 1'b1
    } sac_seq_state_t;

    // analog source index: 0..7 ordinary inputs, 8/9 extended inputs
    function automatic logic [3:0] sourceOf(input logic extSel, input logic [2:0] ch);
        sourceOf = extSel ? (ch[0] ? 4'h9 : 4'h8) : {1'b0, ch};
    endfunction : sourceOf

    // cycles per conversion for resolution and sample-and-hold
    function automatic logic [6:0] cyclesOf(input logic res10, input logic shEn);
        if (shEn) begin
            cyclesOf = res10 ? CYC_10_SH : CYC_8_SH;
        end else begin
            cyclesOf = res10 ? CYC_10_PLAIN : CYC_8_PLAIN;
        end
    endfunction : cyclesOf
endpackage : sac_pkg

// ---- hdl/sac_clock_div.sv ----
// conversion clock tick generator: undivided, /2 or /4 of the source clock
// assumes the select bits are held steady while a conversion runs
`timescale 1ns/1ps
module sac_clock_div import sac_pkg::*; (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // selects
    input wire logic fsel0,
    input wire logic fsel1,
    // tick
    output logic tick
);
    logic [1:0] divCntReg;
    logic tickReg;
    wire logic tickNext;

    assign tickNext = fsel1 | (fsel0 ? divCntReg[0] : (divCntReg == 2'h3)); // RULE12 RULE16
    assign tick = tickReg;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            divCntReg <= 2'h0;
            tickReg <= 1'b0;
        end else begin
            divCntReg <= divCntReg + 2'h1;
            tickReg <= tickNext;
        end
    end
endmodule : sac_clock_div

// ---- hdl/sac_sequencer.sv ----
// successive-approximation sequencer: counts conversion cycles and drives the dac code
// assumes cmpHigh is high while the sampled input is at or above dacCode
`timescale 1ns/1ps
module sac_sequencer import sac_pkg::*; (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // control
    input wire logic tick,
    input wire logic start,
    input wire logic res10,
    input wire logic shEn,
    input wire logic cmpHigh,
    // status and result
    output logic busy,
    output logic done,
    output logic sampling,
    output logic [9:0] result,
    output logic [9:0] dacCode
);
    sac_seq_state_t stateReg;
    logic [6:0] cntReg;
    logic [9:0] accReg;
    logic [9:0] dacReg;
    logic [9:0] resultReg;
    logic doneReg;
    logic samplingReg;
    wire logic [6:0] total;
    wire logic [6:0] decideAt;
    wire logic deciding;
    wire logic lastTick;
    wire logic [3:0] pos;
    wire logic [9:0] bitMask;
    wire logic [9:0] accNext;

    assign total = cyclesOf(res10, shEn); // RULE5 RULE6
    assign decideAt = total - {3'h0, (res10 ? BITS_10 : BITS_8)}; // RULE15
    assign deciding = (stateReg == SEQ_CONV) && tick && (cntReg >= decideAt);
    assign lastTick = (stateReg == SEQ_CONV) && tick && (cntReg == total - 7'd1);
    assign pos = 4'(total - 7'd1 - cntReg) + (res10 ? 4'h0 : 4'h2);
    assign bitMask = 10'h001 << pos;
    assign accNext = cmpHigh ? (accReg | bitMask) : accReg;
    assign busy = (stateReg == SEQ_CONV);
    assign done = doneReg;
    assign sampling = samplingReg;
    assign result = resultReg;
    assign dacCode = dacReg;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            stateReg <= SEQ_IDLE;
            cntReg <= 7'h00;
            accReg <= 10'h000;
            dacReg <= 10'h000;
            resultReg <= RESULT_RESET;
            doneReg <= 1'b0;
            samplingReg <= 1'b0;
        end else begin
            doneReg <= 1'b0;
            case (stateReg)
                SEQ_IDLE: begin
                    samplingReg <= 1'b0;
                    if (start) begin
                        stateReg <= SEQ_CONV;
                    end
                end
                SEQ_CONV: begin
                    samplingReg <= (cntReg < decideAt);
                    if (lastTick && !start) begin
                        stateReg <= SEQ_IDLE; // RULE17
                    end
                end
                default: begin
                    stateReg <= SEQ_IDLE;
                end
            endcase
            if (start) begin
                cntReg <= 7'h00;
                accReg <= 10'h000;
                dacReg <= 10'h200;
            end else if (stateReg == SEQ_CONV && tick) begin
                cntReg <= cntReg + 7'd1;
                if (deciding) begin
                    accReg <= accNext;
                    dacReg <= accNext | (lastTick ? 10'h000 : (bitMask >> 1));
                end
                if (lastTick) begin
                    doneReg <= 1'b1;
                    resultReg <= res10 ? accNext : {2'h0, accNext[9:2]}; // RULE15
                end
            end
        end
    end
endmodule : sac_sequencer

// ---- hdl/sac_adc_control.sv ----
// 10-bit successive-approximation converter control with AXI4-Lite registers
// assumes a comparator and resistor ladder outside; all inputs synchronous to clk_sys
//
// Functional notes
// RULE1: three-bit channel code n selects ordinary analog input n.
// RULE2: eight ordinary inputs plus two extended inputs are conversion sources.
// RULE3: software trigger starts a conversion when the start flag goes zero to one.
// RULE4: external trigger starts on each falling edge while start flag is one; retriggerable.
// RULE5: without sample-and-hold, 49 cycles at 8 bits, 59 at 10 bits.
// RULE6: with sample-and-hold, 28 cycles at 8 bits, 33 at 10 bits.
// RULE7: each result lands in the result register of the converted channel.
// RULE8: in 10-bit mode low eight bits at even byte, upper bits at odd.
// RULE9: reference-connect bit attaches the ladder when set, detaches when clear.
// RULE10: software sets reference-connect before starting any conversion.
// RULE11: software sets every analog pin's port direction to input first.
// RULE12: conversion clock is the source clock undivided, divided by two or four.
// RULE13: software keeps the conversion clock at or below 10 MHz.
// RULE14: software keeps conversion clock above 250 kHz, or 1 MHz with sample-and-hold.
// RULE15: resolution bit zero gives 8-bit conversion, one gives 10-bit.
// RULE16: frequency bit zero gives divide by four, one divide by two.
// RULE17: one-shot mode converts once per trigger, then returns to idle.
//
// The register addresses and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ps
module sac_adc_control import sac_pkg::*; #(
    parameter int ADDR_W = 8
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // axi4-lite write address and data
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    // axi4-lite write response
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    // axi4-lite read
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    // trigger and analog front end
    input wire logic external_trigger_input,
    input wire logic cmpHigh,
    output logic [3:0] analogSel,
    output logic [9:0] dacCode,
    output logic sampleHold,
    output logic refConnect,
    output logic convBusy
);
    logic awreadyReg;
    logic wreadyReg;
    logic awGotReg;
    logic wGotReg;
    logic [7:0] awAddrReg;
    logic [31:0] wDataReg;
    logic [3:0] wStrbReg;
    logic bvalidReg;
    logic [1:0] brespReg;
    logic arreadyReg;
    logic rvalidReg;
    logic [31:0] rdataReg;
    logic [1:0] rrespReg;
    logic [7:0] ctrl0Reg;
    logic [7:0] ctrl1Reg;
    logic trigPrevReg;
    logic [3:0] chanLatReg;
    logic [3:0] analogSelReg;
    logic refConnectReg;
    logic [9:0] resultMem [NUM_SOURCES];
    wire logic tick;
    wire logic seqBusy;
    wire logic seqDone;
    wire logic seqSampling;
    wire logic [9:0] seqResult;

    // write channel
    wire logic awHs = s_axi_awvalid & awreadyReg;
    wire logic wHs = s_axi_wvalid & wreadyReg;
    wire logic doWrite = awGotReg & wGotReg & ~bvalidReg;
    wire logic awGotNext = ~doWrite & (awGotReg | awHs);
    wire logic wGotNext = ~doWrite & (wGotReg | wHs);
    wire logic bvalidNext = doWrite | (bvalidReg & ~s_axi_bready);
    wire logic wrCtrl0 = doWrite && (awAddrReg == ADDR_CTRL0) && wStrbReg[0];
    wire logic wrCtrl1 = doWrite && (awAddrReg == ADDR_CTRL1) && wStrbReg[0];
    wire logic wrMapped = (awAddrReg == ADDR_CTRL0) || (awAddrReg == ADDR_CTRL1);

    // read channel
    wire logic arHs = s_axi_arvalid & arreadyReg;
    wire logic rvalidNext = arHs | (rvalidReg & ~s_axi_rready);
    wire logic [7:0] rdAddr = 8'(s_axi_araddr);
    wire logic [7:0] rdOffset = rdAddr - ADDR_RESULT0;
    wire logic rdResult = (rdAddr >= ADDR_RESULT0) && (rdOffset[1:0] == 2'h0)
        && (rdOffset[7:2] < 6'(NUM_SOURCES));
    wire logic [3:0] rdIndex = rdOffset[5:2];
    wire logic [31:0] statusWord = {24'h000000, chanLatReg, 1'b0, seqSampling, 1'b0, seqBusy};
    wire logic rdMapped = rdResult || (rdAddr == ADDR_CTRL0) || (rdAddr == ADDR_CTRL1)
        || (rdAddr == ADDR_STATUS);
    // result word: low byte at even byte address, upper bits at odd byte
    wire logic [31:0] resultWord = rdResult ? {22'h000000, resultMem[rdIndex]} : 32'h00000000; // RULE8
    wire logic [31:0] rdMux = (rdAddr == ADDR_CTRL0) ? {24'h000000, ctrl0Reg}
        : (rdAddr == ADDR_CTRL1) ? {24'h000000, ctrl1Reg}
        : (rdAddr == ADDR_STATUS) ? statusWord : resultWord;

    // start conditions
    wire logic [7:0] ctrl0Wr = wDataReg[7:0];
    wire logic swStart = wrCtrl0 && !ctrl0Wr[TRG_BIT] && ctrl0Wr[START_BIT]
        && !ctrl0Reg[START_BIT]; // RULE3
    wire logic extFall = trigPrevReg && !external_trigger_input;
    wire logic extStart = ctrl0Reg[TRG_BIT] && ctrl0Reg[START_BIT] && extFall; // RULE4
    wire logic startPulse = swStart | extStart;
    wire logic [3:0] srcNow = sourceOf(ctrl1Reg[EXT_BIT], ctrl0Reg[CH_LSB +: 3]); // RULE1 RULE2
    wire logic [3:0] srcStart = swStart ? sourceOf(ctrl1Reg[EXT_BIT], ctrl0Wr[CH_LSB +: 3]) : srcNow;

    assign s_axi_awready = awreadyReg;
    assign s_axi_wready = wreadyReg;
    assign s_axi_bvalid = bvalidReg;
    assign s_axi_bresp = brespReg;
    assign s_axi_arready = arreadyReg;
    assign s_axi_rvalid = rvalidReg;
    assign s_axi_rdata = rdataReg;
    assign s_axi_rresp = rrespReg;
    assign analogSel = analogSelReg;
    assign refConnect = refConnectReg;
    assign convBusy = seqBusy;
    assign sampleHold = seqSampling;

    sac_clock_div u_clock_div (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .fsel0(ctrl0Reg[FSEL0_BIT]),
        .fsel1(ctrl1Reg[FSEL1_BIT]),
        .tick(tick)
    );

    sac_sequencer u_sequencer (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .tick(tick),
        .start(startPulse),
        .res10(ctrl1Reg[RES_BIT]),
        .shEn(ctrl1Reg[SH_BIT]),
        .cmpHigh(cmpHigh),
        .busy(seqBusy),
        .done(seqDone),
        .sampling(seqSampling),
        .result(seqResult),
        .dacCode(dacCode)
    );

    // bus handshakes
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            awreadyReg <= 1'b0;
            wreadyReg <= 1'b0;
            awGotReg <= 1'b0;
            wGotReg <= 1'b0;
            bvalidReg <= 1'b0;
            arreadyReg <= 1'b0;
            rvalidReg <= 1'b0;
        end else begin
            awGotReg <= awGotNext;
            wGotReg <= wGotNext;
            bvalidReg <= bvalidNext;
            awreadyReg <= ~awGotNext & ~bvalidNext;
            wreadyReg <= ~wGotNext & ~bvalidNext;
            rvalidReg <= rvalidNext;
            arreadyReg <= ~rvalidNext;
        end
    end

    // bus payloads
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            awAddrReg <= 8'h00;
            wDataReg <= 32'h00000000;
            wStrbReg <= 4'h0;
            brespReg <= RESP_OKAY;
            rdataReg <= 32'h00000000;
            rrespReg <= RESP_OKAY;
        end else begin
            if (awHs) begin
                awAddrReg <= 8'(s_axi_awaddr);
            end
            if (wHs) begin
                wDataReg <= s_axi_wdata;
                wStrbReg <= s_axi_wstrb;
            end
            if (doWrite) begin
                brespReg <= wrMapped ? RESP_OKAY : RESP_SLVERR;
            end
            if (arHs) begin
                rdataReg <= rdMapped ? rdMux : 32'h00000000;
                rrespReg <= rdMapped ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    // control registers; a software write wins over the one-shot clear
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ctrl0Reg <= CTRL0_RESET;
            ctrl1Reg <= CTRL1_RESET;
            refConnectReg <= 1'b0;
        end else begin
            if (wrCtrl0) begin
                ctrl0Reg <= ctrl0Wr;
            end else if (seqDone && !ctrl0Reg[TRG_BIT]) begin
                ctrl0Reg[START_BIT] <= 1'b0; // RULE17
            end
            if (wrCtrl1) begin
                ctrl1Reg <= wDataReg[7:0];
            end
            refConnectReg <= ctrl1Reg[VREF_BIT]; // RULE9
        end
    end

    // trigger edge, source latch and results
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            trigPrevReg <= 1'b1;
            chanLatReg <= 4'h0;
            analogSelReg <= 4'h0;
            for (int i = 0; i < NUM_SOURCES; i++) begin
                resultMem[i] <= RESULT_RESET;
            end
        end else begin
            trigPrevReg <= external_trigger_input;
            if (startPulse) begin
                chanLatReg <= srcStart; // RULE1 RULE2
                analogSelReg <= srcStart;
            end
            if (seqDone) begin
                resultMem[chanLatReg] <= seqResult; // RULE7
            end
        end
    end

    // helper: conversion-clock ticks seen in the running conversion
    logic [6:0] tickSeenReg;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            tickSeenReg <= 7'h00;
        end else if (startPulse) begin
            tickSeenReg <= 7'h00;
        end else if (seqBusy && tick) begin
            tickSeenReg <= tickSeenReg + 7'd1;
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    property p_sw_start;
        swStart |=> seqBusy && analogSelReg == $past(srcStart);
    endproperty
    a_sw_start: assert property (p_sw_start) else $error("software start did not begin a conversion"); // RULE3

    property p_ext_start;
        ctrl0Reg[TRG_BIT] && ctrl0Reg[START_BIT] && trigPrevReg && !external_trigger_input
            && !wrCtrl0 |=> seqBusy && tickSeenReg == 7'd0;
    endproperty
    a_ext_start: assert property (p_ext_start) else $error("trigger falling edge did not start"); // RULE4

    property p_len_plain;
        seqDone && !ctrl1Reg[SH_BIT] |-> $past(tickSeenReg) + 7'd1 == (ctrl1Reg[RES_BIT] ? 7'd59 : 7'd49);
    endproperty
    a_len_plain: assert property (p_len_plain) else $error("plain conversion length wrong"); // RULE5

    property p_len_sh;
        seqDone && ctrl1Reg[SH_BIT] |-> $past(tickSeenReg) + 7'd1 == (ctrl1Reg[RES_BIT] ? 7'd33 : 7'd28);
    endproperty
    a_len_sh: assert property (p_len_sh) else $error("sample-and-hold conversion length wrong"); // RULE6

    property p_store;
        seqDone |=> resultMem[$past(chanLatReg)] == $past(seqResult);
    endproperty
    a_store: assert property (p_store) else $error("result not stored at converted channel"); // RULE7

    property p_res8;
        seqDone && !ctrl1Reg[RES_BIT] |-> seqResult[9:8] == 2'h0;
    endproperty
    a_res8: assert property (p_res8) else $error("8-bit result has upper bits set"); // RULE15

    property p_vref;
        $changed(ctrl1Reg[VREF_BIT]) |=> refConnect == $past(ctrl1Reg[VREF_BIT]);
    endproperty
    a_vref: assert property (p_vref) else $error("reference connect did not follow its bit"); // RULE9

    property p_div4;
        tick && !ctrl1Reg[FSEL1_BIT] && !ctrl0Reg[FSEL0_BIT] && $past(!ctrl1Reg[FSEL1_BIT] && !ctrl0Reg[FSEL0_BIT])
            && !wrCtrl0 && !wrCtrl1 |=> !tick [*3] ##1 tick;
    endproperty
    a_div4: assert property (p_div4) else $error("divide-by-four tick spacing wrong"); // RULE12 RULE16

    property p_one_shot;
        seqDone && !ctrl0Reg[TRG_BIT] && !startPulse && !wrCtrl0 |=> !ctrl0Reg[START_BIT] && !seqBusy;
    endproperty
    a_one_shot: assert property (p_one_shot) else $error("one-shot did not return to idle"); // RULE17

    property p_ext_src;
        startPulse && ctrl1Reg[EXT_BIT] |=> analogSelReg[3:1] == 3'h4;
    endproperty
    a_ext_src: assert property (p_ext_src) else $error("extended source not selected"); // RULE2

    c_sw_conv: cover property (swStart ##[1:300] seqDone);
    c_ext_retrig: cover property (extStart ##[1:50] extStart);
    c_sh10: cover property (seqDone && ctrl1Reg[SH_BIT] && ctrl1Reg[RES_BIT]);
endmodule : sac_adc_control

// ---- testbench/sac_far_model.sv ----
// analog sources and comparator at the far side of the converter control
// assumes dacCode is compared against the level of the selected source
`timescale 1ns/1ps
module sac_far_model (
    // front end from the converter
    input wire logic [3:0] analogSel,
    input wire logic [9:0] dacCode,
    input wire logic refConnect,
    // comparator back to the converter
    output logic cmpHigh
);
    // ten sources on a fixed ramp of levels
    // sources only feed the converter and are never driven back from it
    wire [9:0] level = 10'h05A + 10'h05F * {6'h00, analogSel};
    // with the ladder detached there is no reference, so the comparator stays low
    assign cmpHigh = refConnect && (level >= dacCode);
endmodule : sac_far_model

// ---- testbench/tb_sac_adc_control.sv ----
// self-checking bench for the converter control over its AXI4-Lite registers
// assumes the far-side model answers the comparator combinationally
`timescale 1ns/1ps
module tb_sac_adc_control import sac_pkg::*; ;
    logic clk_sys = 1'b0, rst_n = 1'b0, awV = 1'b0, wV = 1'b0, bR = 1'b0, arV = 1'b0, rR = 1'b0, trig = 1'b1;
    logic [7:0] awA = 8'h00, arA = 8'h00;
    logic [31:0] wD = 32'h0, v;
    logic [3:0] wS = 4'h0, selSeen = 4'h0;
    logic [1:0] r;
    wire awRdy, wRdy, bV, arRdy, rV, cmpHigh, refConnect, convBusy, sh;
    wire [1:0] bResp, rResp;
    wire [31:0] rD;
    wire [3:0] analogSel;
    wire [9:0] dacCode;
    int err_count = 0, compares = 0, busyCnt = 0, lastLen = 0;

    sac_adc_control #(.ADDR_W(8)) i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .s_axi_awvalid(awV),
        .s_axi_awready(awRdy), .s_axi_awaddr(awA), .s_axi_wvalid(wV), .s_axi_wready(wRdy), .s_axi_wdata(wD),
        .s_axi_wstrb(wS), .s_axi_bvalid(bV), .s_axi_bready(bR), .s_axi_bresp(bResp), .s_axi_arvalid(arV),
        .s_axi_arready(arRdy), .s_axi_araddr(arA), .s_axi_rvalid(rV), .s_axi_rready(rR), .s_axi_rdata(rD),
        .s_axi_rresp(rResp), .external_trigger_input(trig), .cmpHigh(cmpHigh), .analogSel(analogSel),
        .dacCode(dacCode), .sampleHold(sh), .refConnect(refConnect), .convBusy(convBusy));
    sac_far_model i_far (.analogSel(analogSel), .dacCode(dacCode), .refConnect(refConnect), .cmpHigh(cmpHigh));

    initial forever #20 clk_sys = ~clk_sys;

    // busy length and selected source of the last conversion
    always @(posedge clk_sys) begin
        if (convBusy === 1'b1) begin
            busyCnt <= busyCnt + 1;
            selSeen <= analogSel;
        end else if (busyCnt != 0) begin
            lastLen <= busyCnt;
            busyCnt <= 0;
        end
    end

    task automatic conclude;
        if (err_count == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : conclude
    task automatic tmo;
        err_count++;
        conclude();
    endtask : tmo
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            err_count++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic chkRange(input string nm, input int e, input int g, input int tol);
        compares++;
        if (g < e - tol || g > e + tol) begin
            err_count++;
            $display("BAD %s expected %0d seen %0d", nm, e, g);
        end
    endtask : chkRange
    function automatic logic [9:0] lvl(input logic [3:0] s);
        lvl = 10'h05A + 10'h05F * {6'h00, s};
    endfunction : lvl

    task automatic axiWrite(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
        int n;
        logic aw, w;
        aw = 1'b0;
        w = 1'b0;
        n = 0;
        @(posedge clk_sys);
        awV <= 1'b1; wV <= 1'b1; awA <= a; wD <= d; wS <= 4'hF; bR <= 1'b1;
        while (!(aw && w)) begin
            @(posedge clk_sys);
            if (awV && awRdy === 1'b1) begin
                aw = 1'b1;
                awV <= 1'b0;
            end
            if (wV && wRdy === 1'b1) begin
                w = 1'b1;
                wV <= 1'b0;
            end
            if (++n > 200) tmo();
        end
        while (bV !== 1'b1) begin
            @(posedge clk_sys);
            if (++n > 400) tmo();
        end
        resp = bResp;
        bR <= 1'b0;
    endtask : axiWrite

    task automatic axiRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
        int n;
        n = 0;
        @(posedge clk_sys);
        arV <= 1'b1; arA <= a; rR <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (++n > 200) tmo();
        end while (arRdy !== 1'b1);
        arV <= 1'b0;
        do begin
            @(posedge clk_sys);
            if (++n > 400) tmo();
        end while (rV !== 1'b1);
        d = rD;
        resp = rResp;
        rR <= 1'b0;
    endtask : axiRead

    task automatic waitIdle;
        int k;
        k = 0;
        while (convBusy !== 1'b1) begin
            @(posedge clk_sys);
            if (++k > 300) tmo();
        end
        while (convBusy !== 1'b0) begin
            @(posedge clk_sys);
            if (++k > 4000) tmo();
        end
        repeat (2) @(posedge clk_sys);
    endtask : waitIdle

    // software-started conversion of one source, then length, source, flag and result checks
    task automatic conv(input logic [7:0] c1, input logic [7:0] c0, input logic [3:0] src, input int d);
        int n;
        logic [9:0] e;
        n = c1[2] ? (c1[3] ? 33 : 28) : (c1[3] ? 59 : 49);
        e = lvl(src);
        axiWrite(ADDR_CTRL1, {24'h0, c1}, r);
        axiWrite(ADDR_CTRL0, {24'h0, c0 | 8'h40}, r);
        chk("ctrl0 bresp", {30'h0, RESP_OKAY}, {30'h0, r});
        waitIdle();
        chkRange("busy cycles", n * d, lastLen, d);
        chk("analogSel", {28'h0, src}, {28'h0, selSeen});
        axiRead(ADDR_CTRL0, v, r);
        chk("start flag", 0, {31'h0, v[6]});
        axiRead(ADDR_RESULT0 + {2'b00, src, 2'b00}, v, r);
        if (c1[3]) begin
            chk("result low", {24'h0, e[7:0]}, {24'h0, v[7:0]});
            chk("result high", {30'h0, e[9:8]}, {30'h0, v[9:8]});
        end else begin
            chk("result 8bit", {24'h0, e[9:2]}, {24'h0, v[7:0]});
        end
    endtask : conv

    initial begin
        repeat (16) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk_sys);
        axiRead(ADDR_CTRL0, v, r);
        chk("ctrl0 reset", {24'h0, CTRL0_RESET}, v);
        axiRead(ADDR_CTRL1, v, r);
        chk("ctrl1 reset", {24'h0, CTRL1_RESET}, v);
        chk("ladder off", 0, {31'h0, refConnect});
        axiRead(8'h0C, v, r);
        chk("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, r});
        chk("unmapped data", 0, v);
        axiWrite(ADDR_RESULT0, 32'h3FF, r);
        chk("ro write resp", {30'h0, RESP_SLVERR}, {30'h0, r});
        axiWrite(ADDR_CTRL1, 32'h20, r);
        repeat (2) @(posedge clk_sys);
        chk("ladder on", 1, {31'h0, refConnect});
        // every source, 10-bit with sample-and-hold, divide by four
        for (int s = 0; s < 10; s++) begin
            conv(s >= 8 ? 8'h2D : 8'h2C, {5'h00, s[2:0]}, s[3:0], 4);
        end
        conv(8'h20, 8'h05, 4'h5, 4);
        conv(8'h28, 8'h06, 4'h6, 4);
        conv(8'h24, 8'h03, 4'h3, 4);
        conv(8'h20, 8'h87, 4'h7, 2);
        conv(8'h30, 8'h02, 4'h2, 1);
        // external trigger with a retrigger in mid-conversion
        axiWrite(ADDR_CTRL1, 32'h28, r);
        axiWrite(ADDR_CTRL0, 32'h64, r);
        repeat (4) @(posedge clk_sys);
        chk("idle until edge", 0, {31'h0, convBusy});
        trig <= 1'b0;
        repeat (10) @(posedge clk_sys);
        trig <= 1'b1;
        @(posedge clk_sys);
        trig <= 1'b0;
        waitIdle();
        chkRange("retrigger busy", 11 + 59 * 4, lastLen, 4);
        trig <= 1'b1;
        @(posedge clk_sys);
        trig <= 1'b0;
        repeat (4) @(posedge clk_sys);
        axiRead(ADDR_STATUS, v, r);
        chk("status", 32'h00000045, v);
        chk("sampleHold", 1, {31'h0, sh});
        waitIdle();
        chkRange("second trigger", 59 * 4, lastLen, 4);
        chk("sampleHold idle", 0, {31'h0, sh});
        axiRead(ADDR_RESULT0 + 8'h10, v, r);
        chk("ext result", {22'h0, lvl(4'h4)}, {22'h0, v[9:0]});
        axiWrite(ADDR_CTRL0, 32'h0, r);
        axiWrite(ADDR_CTRL1, 32'h0, r);
        repeat (2) @(posedge clk_sys);
        chk("ladder off again", 0, {31'h0, refConnect});
        conclude();
    end
endmodule : tb_sac_adc_control
